// ===== pie_cpu_model.sv
// CPU side model: accepts offers and grants stolen cycles after a delay.
// Assumes it shares the controller clock and reset.
`timescale 1ns/1ps
module pie_cpu_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Controller requests and answer delay
  input wire logic i_irq_req,
  input wire logic i_steal_req,
  input wire logic [3:0] i_dly,
  // One-cycle answers
  output logic o_irq_ack,
  output logic o_steal_gnt
);
  logic [3:0] wait_q;

  // Answer a standing request once, after i_dly+1 cycles
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_q <= 4'h0;
      o_irq_ack <= 1'b0;
      o_steal_gnt <= 1'b0;
    end else if ((i_irq_req || i_steal_req) && !o_irq_ack && !o_steal_gnt) begin
      wait_q <= wait_q + 4'h1;
      o_irq_ack <= i_irq_req && (wait_q == i_dly);
      o_steal_gnt <= i_steal_req && (wait_q == i_dly);
    end else begin
      wait_q <= 4'h0;
      o_irq_ack <= 1'b0;
      o_steal_gnt <= 1'b0;
    end
  end
endmodule // pie_cpu_model

// ===== pie_ctrl.sv
// Prioritized interrupt controller with an eight-channel event-transfer engine.
// Assumes request sources and the CPU run on i_clk; fast pins are asynchronous.
//
// Contract
// (R1) Pending accepted request reaches the CPU within 5 to 12 clocks.
// (R2) Each source is programmed as vectored interrupt or event transfer.
// (R3) A transfer steals one CPU cycle, no suspension, no vector branch.
// (R4) A transfer moves byte or word, then bumps source or destination pointer.
// (R5) Channel counter decrements per service, unless continuous mode is set.
// (R6) Counter reaching zero raises a standard interrupt at the source's vector.
// (R7) Eight independent channels, each with pointers and counter.
// (R8) Each source has request flag, enable flag and priority field.
// (R9) Priority field picks one of sixteen levels used in arbitration.
// (R10) An accepted service is preempted only by strictly higher priority.
// (R11) Each source has its own unshared vector location.
// (R12) Fast external inputs detect rising, falling or both edges.
// (R13) Software trap with a number starts service at that number's vector.
// (R14) Software setting an unused node's request flag is a real request.
// (R15) Vector byte address equals four times the trap number.
// (R16) Hardware traps block standard service, interrupt all but higher traps.
// (R17) Each hardware trap sets its own bit in the trap flag register.
// (R18) Equal top priority resolves to the lowest source index.
// (R19) Request flag clears automatically when the request is accepted.
`timescale 1ns/1ps
module pie_ctrl
  import pie_pkg::*;
#(
  parameter int NODES = pie_pkg::PIE_NODES,
  parameter int FAST = pie_pkg::PIE_FAST,
  parameter int FAST_BASE = pie_pkg::PIE_FAST_BASE,
  parameter int CHANNELS = pie_pkg::PIE_CHANNELS,
  parameter int HW_TRAPS = pie_pkg::PIE_HW_TRAPS
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Node requests and per-node control
  input wire logic [NODES-1:0] i_periph_req,
  input wire logic [NODES-1:0] i_node_sw_set,
  input wire logic [NODES-1:0] i_node_enable,
  input wire logic [NODES-1:0][pie_pkg::PIE_PRIO_W-1:0] i_node_prio,
  input wire logic [NODES-1:0] i_node_xfer,
  input wire logic [NODES-1:0][pie_pkg::PIE_CHAN_W-1:0] i_node_chan,
  output logic [NODES-1:0] o_node_flags,
  // Fast external pins
  input wire logic [FAST-1:0] i_fast_pin,
  input wire logic [FAST-1:0][1:0] i_fast_edge_mode,
  // Traps
  input wire logic i_sw_trap,
  input wire logic [pie_pkg::PIE_TRAP_W-1:0] i_sw_trap_num,
  input wire logic [HW_TRAPS-1:0] i_hw_trap,
  input wire logic [HW_TRAPS-1:0] i_trap_flag_clr,
  output logic [HW_TRAPS-1:0] o_trap_flags,
  // CPU status
  input wire logic [pie_pkg::PIE_PRIO_W-1:0] i_cpu_level,
  input wire logic i_cpu_in_trap,
  input wire logic [pie_pkg::PIE_HW_IDX_W-1:0] i_cpu_trap_idx,
  // Interrupt offer to the CPU
  output logic o_irq_req,
  output logic [pie_pkg::PIE_VEC_W-1:0] o_irq_vec,
  output logic [pie_pkg::PIE_TRAP_W-1:0] o_irq_trap_num,
  output logic [pie_pkg::PIE_PRIO_W-1:0] o_irq_prio,
  output logic o_irq_hw_trap,
  input wire logic i_irq_ack,
  // Cycle steal for transfers
  output logic o_steal_req,
  input wire logic i_steal_gnt,
  output logic o_mv_valid,
  output logic [pie_pkg::PIE_ADDR_W-1:0] o_mv_src,
  output logic [pie_pkg::PIE_ADDR_W-1:0] o_mv_dst,
  output logic o_mv_word,
  // Channel programming
  input wire logic i_ch_load,
  input wire logic [pie_pkg::PIE_CHAN_W-1:0] i_ch_sel,
  input wire logic [pie_pkg::PIE_ADDR_W-1:0] i_ch_src,
  input wire logic [pie_pkg::PIE_ADDR_W-1:0] i_ch_dst,
  input wire logic [pie_pkg::PIE_CNT_W-1:0] i_ch_count,
  input wire logic i_ch_cont,
  input wire logic i_ch_word,
  input wire logic i_ch_inc_dst,
  output logic [CHANNELS-1:0][pie_pkg::PIE_CNT_W-1:0] o_ch_count
);
  import pie_pkg::*;

  localparam int IDX_W = $clog2(NODES);

  pie_xfer_if #(.CHAN_W(PIE_CHAN_W)) xf ();

  pie_state_t state_q;
  pie_kind_t kind_q;
  logic [NODES-1:0] flag_q, force_std_q, req_in, elig, accept_clr, zero_set;
  logic [FAST-1:0] sync1_q, sync2_q, prev_q, fast_edge;
  logic [HW_TRAPS-1:0] hw_pend_q, trap_flag_q;
  logic sw_pend_q;
  logic [PIE_TRAP_W-1:0] sw_num_q;
  logic [IDX_W-1:0] sel_q, best_idx;
  logic [PIE_HW_IDX_W-1:0] hw_sel_q, hw_idx;
  logic [PIE_PRIO_W-1:0] best_prio;
  logic found, hw_found, sel_xfer_q, sent_q;
  logic [3:0] wait_q;

  // Two-flop synchronisers on the fast pins
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end else begin
      sync1_q <= i_fast_pin;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // Programmable edge detection per fast pin
  for (genvar f = 0; f < FAST; f++) begin : g_edge
    always_comb begin
      unique case (pie_edge_t'(i_fast_edge_mode[f]))
        PIE_EDGE_OFF: fast_edge[f] = 1'b0;
        PIE_EDGE_RISE: fast_edge[f] = sync2_q[f] & ~prev_q[f]; // [R12]
        PIE_EDGE_FALL: fast_edge[f] = ~sync2_q[f] & prev_q[f]; // [R12]
        PIE_EDGE_BOTH: fast_edge[f] = sync2_q[f] ^ prev_q[f]; // [R12]
      endcase
    end
  end

  // Request sources per node; fast pins join their nodes
  always_comb begin
    req_in = i_periph_req | i_node_sw_set; // [R14]
    for (int f = 0; f < FAST; f++) begin
      req_in[FAST_BASE + f] = req_in[FAST_BASE + f] | fast_edge[f];
    end
  end

  // Flags cleared on acceptance, set wins over clear
  always_comb begin
    accept_clr = '0;
    zero_set = '0;
    if (state_q == PIE_ST_OFFER && i_irq_ack && kind_q == PIE_KIND_NODE) begin
      accept_clr[sel_q] = 1'b1; // [R19]
    end
    if (xf.go) begin
      accept_clr[sel_q] = 1'b1; // [R19]
    end
    if (state_q == PIE_ST_XFER && xf.done && xf.zero) begin
      zero_set[sel_q] = 1'b1; // [R6]
    end
  end

  // Node request flags and the force-standard marks
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag_q <= {NODES{PIE_FLAG_RST}};
      force_std_q <= '0;
    end else begin
      flag_q <= req_in | zero_set | (flag_q & ~accept_clr); // [R8]
      force_std_q <= zero_set | (force_std_q & ~accept_clr);
    end
  end

  // Eligibility: enabled, strictly above CPU level, no trap running
  always_comb begin
    for (int i = 0; i < NODES; i++) begin
      elig[i] = flag_q[i] && i_node_enable[i] && !i_cpu_in_trap // [R16]
                && (i_node_prio[i] > i_cpu_level); // [R10]
    end
  end

  // Arbitration: highest level, lowest index on a tie
  always_comb begin
    found = 1'b0;
    best_prio = '0;
    best_idx = '0;
    for (int i = 0; i < NODES; i++) begin
      if (elig[i] && (!found || i_node_prio[i] > best_prio)) begin // [R9] [R18]
        found = 1'b1;
        best_prio = i_node_prio[i];
        best_idx = IDX_W'(i);
      end
    end
  end

  // Hardware trap choice; a running trap yields only to higher ones
  always_comb begin
    hw_found = 1'b0;
    hw_idx = '0;
    for (int t = HW_TRAPS - 1; t >= 0; t--) begin
      if (hw_pend_q[t] && (!i_cpu_in_trap || PIE_HW_IDX_W'(t) < i_cpu_trap_idx)) begin // [R16]
        hw_found = 1'b1;
        hw_idx = PIE_HW_IDX_W'(t);
      end
    end
  end

  // Pending hardware traps and the sticky trap flag register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hw_pend_q <= '0;
      trap_flag_q <= '0;
    end else begin
      for (int t = 0; t < HW_TRAPS; t++) begin
        if (i_hw_trap[t]) begin
          hw_pend_q[t] <= 1'b1;
        end else if (state_q == PIE_ST_OFFER && i_irq_ack && kind_q == PIE_KIND_HW
                     && hw_sel_q == PIE_HW_IDX_W'(t)) begin
          hw_pend_q[t] <= 1'b0;
        end
        trap_flag_q[t] <= i_hw_trap[t] | (trap_flag_q[t] & ~i_trap_flag_clr[t]); // [R17]
      end
    end
  end

  // Pending software trap and its number
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sw_pend_q <= 1'b0;
      sw_num_q <= '0;
    end else if (i_sw_trap) begin
      sw_pend_q <= 1'b1; // [R13]
      sw_num_q <= i_sw_trap_num;
    end else if (state_q == PIE_ST_OFFER && i_irq_ack && kind_q == PIE_KIND_SW) begin
      sw_pend_q <= 1'b0;
    end
  end

  // Sequencer: choose, settle for the response window, offer or steal
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= PIE_ST_IDLE;
      kind_q <= PIE_KIND_NODE;
      sel_q <= '0;
      hw_sel_q <= '0;
      sel_xfer_q <= 1'b0;
      wait_q <= '0;
      sent_q <= 1'b0;
    end else begin
      unique case (state_q)
        PIE_ST_IDLE: begin
          wait_q <= '0;
          sent_q <= 1'b0;
          if (hw_found) begin
            kind_q <= PIE_KIND_HW;
            hw_sel_q <= hw_idx;
            sel_xfer_q <= 1'b0;
            state_q <= PIE_ST_SETTLE;
          end else if (sw_pend_q) begin
            kind_q <= PIE_KIND_SW;
            sel_xfer_q <= 1'b0;
            state_q <= PIE_ST_SETTLE;
          end else if (found) begin
            kind_q <= PIE_KIND_NODE;
            sel_q <= best_idx;
            sel_xfer_q <= i_node_xfer[best_idx] && !force_std_q[best_idx]; // [R2]
            state_q <= PIE_ST_SETTLE;
          end
        end
        PIE_ST_SETTLE: begin
          if (wait_q == PIE_SETTLE_LAST) begin // [R1]
            state_q <= sel_xfer_q ? PIE_ST_XFER : PIE_ST_OFFER; // [R2]
          end else begin
            wait_q <= wait_q + 4'h1;
          end
        end
        PIE_ST_OFFER: begin
          if (i_irq_ack) begin
            state_q <= PIE_ST_IDLE;
          end else if (kind_q == PIE_KIND_NODE && !elig[sel_q]) begin
            state_q <= PIE_ST_IDLE; // [R10]
          end else if (kind_q != PIE_KIND_HW && hw_found) begin
            state_q <= PIE_ST_IDLE; // [R16]
          end
        end
        PIE_ST_XFER: begin
          if (xf.go) begin
            sent_q <= 1'b1;
          end
          if (xf.done) begin
            state_q <= PIE_ST_IDLE; // [R3]
          end
        end
      endcase
    end
  end

  // Offered vector, number and level, captured at selection
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq_vec <= '0;
      o_irq_trap_num <= '0;
      o_irq_prio <= '0;
      o_irq_hw_trap <= 1'b0;
    end else if (state_q == PIE_ST_IDLE) begin
      if (hw_found) begin
        o_irq_trap_num <= PIE_HW_TRAP_NUM[hw_idx];
        o_irq_vec <= pie_vec_of(PIE_HW_TRAP_NUM[hw_idx]); // [R15]
        o_irq_prio <= '1;
        o_irq_hw_trap <= 1'b1;
      end else if (sw_pend_q) begin
        o_irq_trap_num <= sw_num_q;
        o_irq_vec <= pie_vec_of(sw_num_q); // [R13] [R15]
        o_irq_prio <= i_cpu_level;
        o_irq_hw_trap <= 1'b0;
      end else if (found) begin
        o_irq_trap_num <= PIE_NODE_TRAP_BASE + PIE_TRAP_W'(best_idx); // [R11]
        o_irq_vec <= pie_vec_of(PIE_NODE_TRAP_BASE + PIE_TRAP_W'(best_idx)); // [R15]
        o_irq_prio <= best_prio;
        o_irq_hw_trap <= 1'b0;
      end
    end
  end

  // Handshakes and the steal pulse toward the engine
  assign o_irq_req = (state_q == PIE_ST_OFFER);
  assign o_steal_req = (state_q == PIE_ST_XFER) && !sent_q; // [R3]
  assign xf.go = o_steal_req && i_steal_gnt;
  assign xf.chan = i_node_chan[sel_q];
  assign o_node_flags = flag_q;
  assign o_trap_flags = trap_flag_q;

  // Channel storage and moves
  pie_xfer_engine #(
    .CHANNELS(CHANNELS),
    .ADDR_W(PIE_ADDR_W),
    .CNT_W(PIE_CNT_W)
  ) u_engine ( // [R7]
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .xf(xf.engine),
    .i_ch_load(i_ch_load),
    .i_ch_sel(i_ch_sel),
    .i_ch_src(i_ch_src),
    .i_ch_dst(i_ch_dst),
    .i_ch_count(i_ch_count),
    .i_ch_cont(i_ch_cont),
    .i_ch_word(i_ch_word),
    .i_ch_inc_dst(i_ch_inc_dst),
    .o_ch_count(o_ch_count),
    .o_mv_valid(o_mv_valid),
    .o_mv_src(o_mv_src),
    .o_mv_dst(o_mv_dst),
    .o_mv_word(o_mv_word)
  );

endmodule // pie_ctrl

// ===== pie_ctrl_sva.sv
// Checker on the controller top ports, bound below.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module pie_ctrl_sva
  import pie_pkg::*;
#(
  parameter int NODES = 16,
  parameter int HW_TRAPS = 4
) (
  // Clock, reset and request side
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [NODES-1:0] o_node_flags,
  input wire logic i_sw_trap,
  input wire logic [HW_TRAPS-1:0] i_hw_trap,
  input wire logic [HW_TRAPS-1:0] o_trap_flags,
  // CPU side
  input wire logic o_irq_req,
  input wire logic [pie_pkg::PIE_VEC_W-1:0] o_irq_vec,
  input wire logic [pie_pkg::PIE_TRAP_W-1:0] o_irq_trap_num,
  input wire logic [pie_pkg::PIE_PRIO_W-1:0] o_irq_prio,
  input wire logic o_irq_hw_trap,
  input wire logic i_irq_ack,
  input wire logic o_steal_req,
  input wire logic i_steal_gnt,
  input wire logic o_mv_valid
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // Trap flags follow their causes one cycle later
  a_trap_flag_set: assert property (i_hw_trap != '0 |=>
    (o_trap_flags & $past(i_hw_trap)) == $past(i_hw_trap)) else $error("trap flag missing");
  a_hw_top_level: assert property (o_irq_req && o_irq_hw_trap |-> o_irq_prio == 4'hF)
    else $error("hw trap level wrong");
  // Stolen cycle gives exactly one move
  a_steal_then_move: assert property (o_steal_req && i_steal_gnt |=>
    o_mv_valid && !o_steal_req) else $error("grant gave no move");
  a_move_one_cycle: assert property (o_mv_valid |=> !o_mv_valid && !o_steal_req)
    else $error("move longer than one cycle");
  a_one_service: assert property (!(o_irq_req && o_steal_req))
    else $error("offer during steal");
  a_vector_from_number: assert property (o_irq_req |->
    o_irq_vec == {o_irq_trap_num, 2'h0}) else $error("vector not four times number");
  a_ack_ends_offer: assert property (o_irq_req && i_irq_ack |=> !o_irq_req)
    else $error("offer stands after accept");
  // Quiet controller answers a software trap in time
  a_sw_response: assert property (i_sw_trap && o_node_flags == '0 && !o_irq_req
    && !o_steal_req && !o_mv_valid && i_hw_trap == '0 && !$past(i_sw_trap)
    |-> ##[4:11] o_irq_req) else $error("slow response");
endmodule // pie_ctrl_sva

bind pie_ctrl pie_ctrl_sva #(.NODES(NODES), .HW_TRAPS(HW_TRAPS)) u_sva (.*);

// ===== pie_ctrl_tb_top.sv
// Testbench for the interrupt controller.
// Assumes package, design, model and checker are compiled first.
`timescale 1ns/1ps
module pie_ctrl_tb_top;
  import pie_pkg::*;
  logic i_clk, i_rst_n, i_sw_trap, i_cpu_in_trap, i_irq_ack, i_steal_gnt, i_ch_load;
  logic i_ch_cont, i_ch_word, i_ch_inc_dst, o_irq_req, o_irq_hw_trap, o_steal_req;
  logic o_mv_valid, o_mv_word;
  logic [PIE_NODES-1:0] i_periph_req, i_node_sw_set, i_node_enable, i_node_xfer, o_node_flags;
  logic [PIE_NODES-1:0][PIE_PRIO_W-1:0] i_node_prio;
  logic [PIE_NODES-1:0][PIE_CHAN_W-1:0] i_node_chan;
  logic [PIE_FAST-1:0] i_fast_pin;
  logic [PIE_FAST-1:0][1:0] i_fast_edge_mode;
  logic [PIE_TRAP_W-1:0] i_sw_trap_num, o_irq_trap_num;
  logic [PIE_HW_TRAPS-1:0] i_hw_trap, i_trap_flag_clr, o_trap_flags;
  logic [PIE_PRIO_W-1:0] i_cpu_level, o_irq_prio;
  logic [PIE_HW_IDX_W-1:0] i_cpu_trap_idx;
  logic [PIE_VEC_W-1:0] o_irq_vec;
  logic [PIE_CHAN_W-1:0] i_ch_sel;
  logic [PIE_ADDR_W-1:0] o_mv_src, o_mv_dst, i_ch_src, i_ch_dst;
  logic [PIE_CNT_W-1:0] i_ch_count;
  logic [PIE_CHANNELS-1:0][PIE_CNT_W-1:0] o_ch_count;
  logic [3:0] cpu_dly;
  int err_count, checks_done, lat;

  pie_ctrl i_dut (.*);
  pie_cpu_model i_cpu (.i_clk, .i_rst_n, .i_irq_req(o_irq_req), .i_steal_req(o_steal_req),
    .i_dly(cpu_dly), .o_irq_ack(i_irq_ack), .o_steal_gnt(i_steal_gnt));

  // Clock of 10 ns
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic check(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("Counts: %0d checks, %0d mismatches", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One-cycle node request, by peripheral or by software
  task automatic pulse(input logic [PIE_NODES-1:0] m, input logic sw);
    @(posedge i_clk);
    if (sw) i_node_sw_set <= m;
    else i_periph_req <= m;
    @(posedge i_clk);
    i_periph_req <= '0;
    i_node_sw_set <= '0;
  endtask

  // Wait for an offer, check it, let the CPU accept
  task automatic offer(input string nm, input logic [7:0] num, input logic [3:0] prio);
    lat = 1;
    #1;
    while (o_irq_req !== 1'b1 && lat < 40) begin
      @(posedge i_clk);
      #1;
      lat++;
    end
    check(nm, o_irq_trap_num, num);
    check("vector", o_irq_vec, {num, 2'h0});
    check("level", o_irq_prio, prio);
    check("kind", o_irq_hw_trap, prio == 4'hF);
    repeat (cpu_dly + 3) @(posedge i_clk);
  endtask

  // No offer and no steal for a while
  task automatic quiet(input string nm);
    logic seen;
    seen = 1'b0;
    repeat (16) begin
      @(posedge i_clk);
      #1;
      seen = seen | o_irq_req | o_steal_req;
    end
    check(nm, seen, 1'b0);
  endtask

  // Wait for one move and check it
  task automatic move(input logic [23:0] s, input logic [23:0] d, input logic w);
    lat = 0;
    while (o_mv_valid !== 1'b1 && lat < 40) begin
      @(posedge i_clk);
      #1;
      lat++;
    end
    check("no offer", o_irq_req, 1'b0);
    check("src", o_mv_src, s);
    check("dst", o_mv_dst, d);
    check("word", o_mv_word, w);
  endtask

  task automatic load(input logic [2:0] c, input logic [23:0] s, d, input logic [7:0] n,
      input logic ct, w, id);
    @(posedge i_clk);
    i_ch_load <= 1'b1;
    i_ch_sel <= c;
    i_ch_src <= s;
    i_ch_dst <= d;
    i_ch_count <= n;
    {i_ch_cont, i_ch_word, i_ch_inc_dst} <= {ct, w, id};
    @(posedge i_clk);
    i_ch_load <= 1'b0;
  endtask

  // Watchdog far beyond the test length
  initial begin
    #300us;
    err_count++;
    finish_test();
  end

  initial begin
    {i_rst_n, i_sw_trap, i_cpu_in_trap, i_ch_load, i_ch_cont, i_ch_word, i_ch_inc_dst} = '0;
    {i_periph_req, i_node_sw_set, i_fast_pin} = '0;
    {i_fast_edge_mode, i_hw_trap, i_trap_flag_clr, i_cpu_level} = '0;
    i_sw_trap_num = 8'h25;
    i_node_xfer = 16'h0210;
    i_node_chan = {18'h0, 3'h5, 12'h0, 3'h3, 12'h0};
    {i_cpu_trap_idx, i_ch_sel, i_ch_src, i_ch_dst, i_ch_count} = '0;
    i_node_enable = '1;
    i_node_prio = {PIE_NODES{4'h8}};
    cpu_dly = 4'h2;
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    // Single nodes, own vectors, node 15 set by software
    for (int k = 0; k < PIE_NODES; k += 5) begin
      pulse(16'h1 << k, k == 15);
      offer("node", 8'h10 + 8'(k), 4'h8);
      check("resp", lat >= PIE_RESP_MIN_CYC && lat <= PIE_RESP_MAX_CYC, 1'b1);
      check("flag clr", o_node_flags[k], 1'b0);
    end
    $display("Test single nodes done");
    @(posedge i_clk);
    i_node_prio[3] <= 4'h9;
    pulse(16'h0088, 1'b0);
    offer("high", 8'h13, 4'h9);
    offer("low", 8'h17, 4'h8);
    pulse(16'h0104, 1'b0);
    offer("tie", 8'h12, 4'h8);
    offer("tie next", 8'h18, 4'h8);
    $display("Test arbitration done");
    @(posedge i_clk);
    i_node_enable[6] <= 1'b0;
    i_cpu_level <= 4'h8;
    pulse(16'h0068, 1'b0);
    offer("above", 8'h13, 4'h9);
    quiet("held");
    check("kept", o_node_flags[6:5], 2'h3);
    @(posedge i_clk);
    i_node_enable[6] <= 1'b1;
    i_cpu_level <= 4'h0;
    offer("freed", 8'h15, 4'h8);
    offer("enabled", 8'h16, 4'h8);
    $display("Test refusal done");
    for (int m = 1; m < 4; m++) begin
      @(posedge i_clk);
      i_fast_edge_mode[0] <= 2'(m);
      i_fast_pin[0] <= 1'b1;
      if (m[0]) offer("rise", 8'h1C, 4'h8);
      else quiet("no rise");
      @(posedge i_clk);
      i_fast_pin[0] <= 1'b0;
      if (m[1]) offer("fall", 8'h1C, 4'h8);
      else quiet("no fall");
    end
    $display("Test fast pins done");
    @(posedge i_clk);
    i_cpu_level <= 4'h4;
    i_sw_trap <= 1'b1;
    @(posedge i_clk);
    i_sw_trap <= 1'b0;
    offer("sw trap", 8'h25, 4'h4);
    @(posedge i_clk);
    i_hw_trap <= 4'h2;
    i_cpu_level <= 4'h0;
    @(posedge i_clk);
    i_hw_trap <= 4'h0;
    #1;
    check("trap flags", o_trap_flags, 4'h2);
    offer("hw trap", 8'h04, 4'hF);
    @(posedge i_clk);
    i_cpu_in_trap <= 1'b1;
    i_cpu_trap_idx <= 2'h1;
    pulse(16'h0001, 1'b0);
    quiet("trap blocks");
    @(posedge i_clk);
    i_hw_trap <= 4'h1;
    i_trap_flag_clr <= 4'h2;
    @(posedge i_clk);
    i_hw_trap <= 4'h0;
    i_trap_flag_clr <= 4'h0;
    #1;
    check("flags swap", o_trap_flags, 4'h1);
    offer("higher trap", 8'h02, 4'hF);
    @(posedge i_clk);
    i_cpu_in_trap <= 1'b0;
    offer("after trap", 8'h10, 4'h8);
    $display("Test traps done");
    load(3'h3, 24'h000100, 24'h000200, 8'h02, 1'b0, 1'b1, 1'b0);
    pulse(16'h0010, 1'b0);
    move(24'h000100, 24'h000200, 1'b1);
    check("count", o_ch_count[3], 8'h01);
    pulse(16'h0010, 1'b0);
    move(24'h000102, 24'h000200, 1'b1);
    offer("at zero", 8'h14, 4'h8);
    load(3'h5, 24'h000400, 24'h000300, 8'h07, 1'b1, 1'b0, 1'b1);
    cpu_dly <= 4'h6;
    for (int k = 0; k < 2; k++) begin
      pulse(16'h0200, 1'b0);
      move(24'h000400, 24'h000300 + 24'(k), 1'b0);
      check("cont count", o_ch_count[5], 8'h07);
    end
    check("other chan", o_ch_count[3], 8'h00);
    $display("Test transfers done");
    finish_test();
  end
endmodule // pie_ctrl_tb_top

// ===== pie_pkg.sv
// Package for the prioritized interrupt and event-transfer controller.
// Assumes one clock domain; all users import pie_pkg::*.
package pie_pkg;

  // Sizes and counts
  localparam int PIE_NODES = 16;
  localparam int PIE_PRIO_W = 4;
  localparam int PIE_CHANNELS = 8;
  localparam int PIE_CHAN_W = 3;
  localparam int PIE_ADDR_W = 24;
  localparam int PIE_CNT_W = 8;
  localparam int PIE_TRAP_W = 8;
  localparam int PIE_VEC_W = 10;
  localparam int PIE_FAST = 4;
  localparam int PIE_FAST_BASE = 12;
  localparam int PIE_HW_TRAPS = 4;
  localparam int PIE_HW_IDX_W = 2;

  // Node trap numbers run upward from this base; vector is trap number shifted by two
  localparam logic [PIE_TRAP_W-1:0] PIE_NODE_TRAP_BASE = 8'h10;

  // Hardware trap numbers, index 0 has the highest priority
  localparam logic [PIE_TRAP_W-1:0] PIE_HW_TRAP_NUM [PIE_HW_TRAPS] = '{
    8'h02, 8'h04, 8'h06, 8'h0A};

  // Response window in CPU clocks, and the settle wait derived from it
  localparam int PIE_RESP_MIN_CYC = 5;
  localparam int PIE_RESP_MAX_CYC = 12;
  localparam logic [3:0] PIE_SETTLE_LAST = 4'(PIE_RESP_MIN_CYC - 3);

  // Reset values
  localparam logic PIE_FLAG_RST = 1'b0;
  localparam logic [PIE_ADDR_W-1:0] PIE_PTR_RST = 24'h000000;
  localparam logic [PIE_CNT_W-1:0] PIE_CNT_RST = 8'h00;

  // Address steps of one move
  localparam logic [PIE_ADDR_W-1:0] PIE_STEP_BYTE = 24'h000001;
  localparam logic [PIE_ADDR_W-1:0] PIE_STEP_WORD = 24'h000002;

  // Edge selection of a fast external input
  typedef enum logic [1:0] {
    PIE_EDGE_OFF  = 2'h0,
    PIE_EDGE_RISE = 2'h1,
    PIE_EDGE_FALL = 2'h2,
    PIE_EDGE_BOTH = 2'h3
  } pie_edge_t;

  // Kind of service being delivered
  typedef enum logic [1:0] {
    PIE_KIND_NODE = 2'h0,
    PIE_KIND_SW   = 2'h1,
    PIE_KIND_HW   = 2'h2
  } pie_kind_t;

  // Controller states, Gray along IDLE-SETTLE-OFFER-XFER
  typedef enum logic [1:0] {
    PIE_ST_IDLE   = 2'h0,
    PIE_ST_SETTLE = 2'h1,
    PIE_ST_OFFER  = 2'h3,
    PIE_ST_XFER   = 2'h2
  } pie_state_t;

  // Vector byte address of a trap number
  function automatic logic [PIE_VEC_W-1:0] pie_vec_of(input logic [PIE_TRAP_W-1:0] num);
    pie_vec_of = {num, 2'h0};
  endfunction

endpackage

// ===== pie_xfer_engine.sv
// Event-transfer engine: channels of pointers and counters, one move per go.
// Assumes the CPU side carries out the move shown on o_mv_* in the stolen cycle.
`timescale 1ns/1ps
module pie_xfer_engine
  import pie_pkg::*;
#(
  parameter int CHANNELS = pie_pkg::PIE_CHANNELS,
  parameter int ADDR_W = pie_pkg::PIE_ADDR_W,
  parameter int CNT_W = pie_pkg::PIE_CNT_W
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Controller link
  pie_xfer_if.engine xf,
  // Channel programming
  input wire logic i_ch_load,
  input wire logic [$clog2(CHANNELS)-1:0] i_ch_sel,
  input wire logic [ADDR_W-1:0] i_ch_src,
  input wire logic [ADDR_W-1:0] i_ch_dst,
  input wire logic [CNT_W-1:0] i_ch_count,
  input wire logic i_ch_cont,
  input wire logic i_ch_word,
  input wire logic i_ch_inc_dst,
  output logic [CHANNELS-1:0][CNT_W-1:0] o_ch_count,
  // Move command
  output logic o_mv_valid,
  output logic [ADDR_W-1:0] o_mv_src,
  output logic [ADDR_W-1:0] o_mv_dst,
  output logic o_mv_word
);
  logic [ADDR_W-1:0] src_q [CHANNELS];
  logic [ADDR_W-1:0] dst_q [CHANNELS];
  logic [CNT_W-1:0] cnt_q [CHANNELS];
  logic [CHANNELS-1:0] cont_q, word_q, incd_q;

  // Channel state; a load beats a move on the same channel
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int c = 0; c < CHANNELS; c++) begin
        src_q[c] <= PIE_PTR_RST;
        dst_q[c] <= PIE_PTR_RST;
        cnt_q[c] <= PIE_CNT_RST;
      end
      cont_q <= '0;
      word_q <= '0;
      incd_q <= '0;
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        if (i_ch_load && i_ch_sel == c[$clog2(CHANNELS)-1:0]) begin
          src_q[c] <= i_ch_src;
          dst_q[c] <= i_ch_dst;
          cnt_q[c] <= i_ch_count;
          cont_q[c] <= i_ch_cont;
          word_q[c] <= i_ch_word;
          incd_q[c] <= i_ch_inc_dst;
        end else if (xf.go && xf.chan == c[$clog2(CHANNELS)-1:0]) begin
          if (incd_q[c]) begin // [R4]
            dst_q[c] <= dst_q[c] + (word_q[c] ? PIE_STEP_WORD : PIE_STEP_BYTE);
          end else begin
            src_q[c] <= src_q[c] + (word_q[c] ? PIE_STEP_WORD : PIE_STEP_BYTE);
          end
          if (!cont_q[c] && cnt_q[c] != '0) begin
            cnt_q[c] <= cnt_q[c] - 1'b1; // [R5]
          end
        end
      end
    end
  end

  // One-cycle move command from the channel selected by go
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mv_valid <= 1'b0;
      o_mv_src <= PIE_PTR_RST;
      o_mv_dst <= PIE_PTR_RST;
      o_mv_word <= 1'b0;
    end else begin
      o_mv_valid <= xf.go; // [R3] [R4]
      if (xf.go) begin
        o_mv_src <= src_q[xf.chan];
        o_mv_dst <= dst_q[xf.chan];
        o_mv_word <= word_q[xf.chan];
      end
    end
  end

  // Completion report; zero when a counting channel's move leaves its counter at zero
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      xf.done <= 1'b0;
      xf.zero <= 1'b0;
    end else begin
      xf.done <= xf.go;
      xf.zero <= xf.go && !cont_q[xf.chan] && cnt_q[xf.chan] <= 1; // [R6]
    end
  end

  // Counter view
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      o_ch_count[c] = cnt_q[c];
    end
  end

endmodule // pie_xfer_engine

// ===== pie_xfer_if.sv
// Carrier between the controller and the event-transfer engine.
// Assumes both ends share i_clk; go is a one-cycle pulse.
`timescale 1ns/1ps
interface pie_xfer_if #(parameter int CHAN_W = 3);
  logic go;
  logic [CHAN_W-1:0] chan;
  logic done;
  logic zero;

  // Controller side
  modport ctrl (output go, output chan, input done, input zero);
  // Engine side
  modport engine (input go, input chan, output done, output zero);
endinterface
